// ===== mcsr_pkg.sv
// package for the monitor configuration and first limit status registers
// assumes an apb slave with 32-bit data; printed offsets are register indices
package mcsr_pkg;
   localparam logic [7:0] MCSR_IDX_CFG     = 8'h40;
   localparam logic [7:0] MCSR_IDX_STAT    = 8'h41;
   localparam logic [9:0] MCSR_ADDR_CFG    = {MCSR_IDX_CFG, 2'b00};
   localparam logic [9:0] MCSR_ADDR_STAT   = {MCSR_IDX_STAT, 2'b00};
   localparam logic [7:0] MCSR_CFG_RST     = 8'h00;
   localparam logic [7:0] MCSR_STAT_RST    = 8'h00;
   localparam int         MCSR_B_RUN       = 0;
   localparam int         MCSR_B_LOCK      = 1;
   localparam int         MCSR_B_RDY       = 2;
   localparam int         MCSR_B_MAX       = 3;
   localparam int         MCSR_B_SKIP      = 5;
   localparam int         MCSR_B_TOOFF     = 6;
   localparam int         MCSR_B_SCALE     = 7;
   localparam int         MCSR_S_LOW_RAIL  = 0;
   localparam int         MCSR_S_SUPPLY    = 2;
   localparam int         MCSR_S_REM1      = 4;
   localparam int         MCSR_S_LOCAL     = 5;
   localparam int         MCSR_S_REM2      = 6;
   localparam int         MCSR_S_SUMMARY   = 7;
   // open-write bits of the configuration register (lock written apart; ready, reserved excluded)
   localparam logic [7:0] MCSR_CFG_WMASK   = 8'he9;
   localparam int         MCSR_NCH         = 5;
   localparam int         MCSR_CLK_HZ      = 20000000;
   localparam int         MCSR_READY_US    = 100;
   localparam int         MCSR_READY_CYC   = (MCSR_READY_US * (MCSR_CLK_HZ / 1000000));

   typedef struct packed {
      logic [7:0] value;
      logic [7:0] low_lim;
      logic [7:0] high_lim;
   } mcsr_chan_t;

   typedef struct packed {
      logic monitor_run;
      logic all_fans_max;
      logic spinup_skip;
      logic bus_timeout_off;
      logic supply_5v;
      logic locked;
   } mcsr_ctrl_t;
endpackage : mcsr_pkg

// ===== mcsr_regs.sv
// configuration and first limit status registers of the thermal/fan monitor
// assumes apb master on the same clock; channel values and limits arrive synchronous
`timescale 1ns/1ps
module mcsr_regs #(
   parameter int READY_CYC = mcsr_pkg::MCSR_READY_CYC
) (
   input  wire logic                                         clock,
   input  wire logic                                         rst,
   input  wire logic                                         psel,
   input  wire logic                                         penable,
   input  wire logic                                         pwrite,
   input  wire logic [9:0]                                   paddr,
   input  wire logic [31:0]                                  pwdata,
   input  wire logic [3:0]                                   pstrb,
   output logic      [31:0]                                  prdata,
   output logic                                              pready,
   output logic                                              pslverr,
   input  wire logic                                         cycle_done,
   input  wire mcsr_pkg::mcsr_chan_t [mcsr_pkg::MCSR_NCH-1:0] chan,
   input  wire logic [7:0]                                   second_status,
   output mcsr_pkg::mcsr_ctrl_t                              ctrl,
   output logic                                              device_ready
);
   initial begin
      if (READY_CYC < 1) $error("READY_CYC must be at least one");
   end

   logic [7:0]  cfg_r;
   logic [7:0]  stat_r;
   logic [31:0] rcnt_r;
   logic        rdy_r;
   logic [6:0]  viol;
   logic        acc;
   logic        hit_cfg;
   logic        hit_stat;
   logic        wr_cfg;
   logic        rd_stat;
   logic [7:0]  cfg_nxt;
   logic [7:0]  stat_nxt;
   logic [7:0]  stat_view;

   assign acc      = psel && penable;
   assign hit_cfg  = (paddr == mcsr_pkg::MCSR_ADDR_CFG);
   assign hit_stat = (paddr == mcsr_pkg::MCSR_ADDR_STAT);
   assign wr_cfg   = acc && pwrite && hit_cfg && pstrb[0];
   assign rd_stat  = acc && !pwrite && hit_stat;
   // zero-wait slave; unmapped addresses answer with an error
   assign pready   = 1'b1;
   assign pslverr  = acc && !(hit_cfg || hit_stat);

   // per-channel comparisons; channels 0..4 map to status bits 0,2,4,5,6
   genvar g;
   generate
      for (g = 0; g < mcsr_pkg::MCSR_NCH; g++) begin : g_cmp
         assign viol[g] = (chan[g].value > chan[g].high_lim) || (chan[g].value <= chan[g].low_lim);
      end
   endgenerate
   assign viol[6:5] = 2'b00;

   // power-up settle counter; no real analog ready indication exists here
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rcnt_r <= '0;
         rdy_r  <= 1'b0;
      end else if (!rdy_r) begin
         rcnt_r <= rcnt_r + 32'h00000001;
         if (rcnt_r == 32'(READY_CYC - 1)) rdy_r <= 1'b1;
      end
   end

   always_comb begin
      cfg_nxt = cfg_r;
      if (cfg_r[mcsr_pkg::MCSR_B_LOCK]) begin
         // locked: only the full-speed bit may change
         cfg_nxt[mcsr_pkg::MCSR_B_MAX] = pwdata[mcsr_pkg::MCSR_B_MAX];
      end else begin
         cfg_nxt = (cfg_r & ~mcsr_pkg::MCSR_CFG_WMASK) | (pwdata[7:0] & mcsr_pkg::MCSR_CFG_WMASK);
         cfg_nxt[mcsr_pkg::MCSR_B_LOCK] = pwdata[mcsr_pkg::MCSR_B_LOCK];
      end
      cfg_nxt[mcsr_pkg::MCSR_B_RDY] = 1'b0;
      cfg_nxt[4] = 1'b0;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) cfg_r <= mcsr_pkg::MCSR_CFG_RST;
      else if (wr_cfg) cfg_r <= cfg_nxt;
   end

   // while running, a read clears only bits whose condition has gone; a new hit on the same edge wins
   always_comb begin
      stat_nxt = stat_r;
      if (rd_stat) stat_nxt = stat_r & {1'b0, viol[4], viol[3], viol[2], 1'b0, viol[1], 1'b0, viol[0]};
      if (cycle_done) begin
         stat_nxt[mcsr_pkg::MCSR_S_LOW_RAIL] = stat_nxt[mcsr_pkg::MCSR_S_LOW_RAIL] | viol[0];
         stat_nxt[mcsr_pkg::MCSR_S_SUPPLY]   = stat_nxt[mcsr_pkg::MCSR_S_SUPPLY] | viol[1];
         stat_nxt[mcsr_pkg::MCSR_S_REM1]     = stat_nxt[mcsr_pkg::MCSR_S_REM1] | viol[2];
         stat_nxt[mcsr_pkg::MCSR_S_LOCAL]    = stat_nxt[mcsr_pkg::MCSR_S_LOCAL] | viol[3];
         stat_nxt[mcsr_pkg::MCSR_S_REM2]     = stat_nxt[mcsr_pkg::MCSR_S_REM2] | viol[4];
      end
      stat_nxt[1] = 1'b0;
      stat_nxt[3] = 1'b0;
      stat_nxt[mcsr_pkg::MCSR_S_SUMMARY] = 1'b0;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) stat_r <= mcsr_pkg::MCSR_STAT_RST;
      else if (!cfg_r[mcsr_pkg::MCSR_B_RUN]) stat_r <= stat_r & ~{8{rd_stat}};
      else stat_r <= stat_nxt;
   end

   assign stat_view = {|second_status, stat_r[6:0]};

   always_ff @(posedge clock or posedge rst) begin
      if (rst) prdata <= '0;
      else if (psel && !penable && !pwrite) begin
         if (paddr == mcsr_pkg::MCSR_ADDR_CFG) prdata <= {24'h000000, cfg_r[7:3], rdy_r, cfg_r[1:0]};
         else if (paddr == mcsr_pkg::MCSR_ADDR_STAT) prdata <= {24'h000000, stat_view};
         else prdata <= '0;
      end
   end

   // limit registers live outside and are never frozen by the lock
   always_comb begin
      ctrl.monitor_run     = cfg_r[mcsr_pkg::MCSR_B_RUN];
      ctrl.all_fans_max    = cfg_r[mcsr_pkg::MCSR_B_MAX];
      ctrl.spinup_skip     = cfg_r[mcsr_pkg::MCSR_B_SKIP];
      ctrl.bus_timeout_off = cfg_r[mcsr_pkg::MCSR_B_TOOFF];
      ctrl.supply_5v       = cfg_r[mcsr_pkg::MCSR_B_SCALE];
      ctrl.locked          = cfg_r[mcsr_pkg::MCSR_B_LOCK];
   end
   assign device_ready = rdy_r;

   property p_lock_sticky;
      @(posedge clock) disable iff (rst) cfg_r[mcsr_pkg::MCSR_B_LOCK] |=> cfg_r[mcsr_pkg::MCSR_B_LOCK];
   endproperty
   a_lock_sticky: assert property (p_lock_sticky) else $error("lock bit dropped");

   property p_run_frozen;
      @(posedge clock) disable iff (rst) cfg_r[mcsr_pkg::MCSR_B_LOCK] |=> $stable(cfg_r[mcsr_pkg::MCSR_B_RUN]);
   endproperty
   a_run_frozen: assert property (p_run_frozen) else $error("run bit changed while locked");

   property p_scale_frozen;
      @(posedge clock) disable iff (rst) cfg_r[mcsr_pkg::MCSR_B_LOCK] |=> $stable(cfg_r[7:5]);
   endproperty
   a_scale_frozen: assert property (p_scale_frozen) else $error("lockable bits changed");

   property p_max_unlocked;
      @(posedge clock) disable iff (rst) wr_cfg |=> cfg_r[mcsr_pkg::MCSR_B_MAX] == $past(pwdata[mcsr_pkg::MCSR_B_MAX]);
   endproperty
   a_max_unlocked: assert property (p_max_unlocked) else $error("full speed write lost");

   property p_reserved;
      @(posedge clock) disable iff (rst) !cfg_r[4] && !stat_r[1] && !stat_r[3];
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit set");

   property p_flag_set;
      @(posedge clock) disable iff (rst) cfg_r[mcsr_pkg::MCSR_B_RUN] && cycle_done && viol[2] |=> stat_r[mcsr_pkg::MCSR_S_REM1];
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("remote one flag not set");

   property p_supply_set;
      @(posedge clock) disable iff (rst) cfg_r[mcsr_pkg::MCSR_B_RUN] && cycle_done && viol[1] |=> stat_r[mcsr_pkg::MCSR_S_SUPPLY];
   endproperty
   a_supply_set: assert property (p_supply_set) else $error("supply flag not set");

   property p_hold_on_read;
      @(posedge clock) disable iff (rst) cfg_r[mcsr_pkg::MCSR_B_RUN] && rd_stat && stat_r[0] && viol[0] |=> stat_r[0];
   endproperty
   a_hold_on_read: assert property (p_hold_on_read) else $error("flag cleared while condition present");

   property p_ready_seq;
      @(posedge clock) disable iff (rst) rdy_r |=> rdy_r;
   endproperty
   a_ready_seq: assert property (p_ready_seq) else $error("ready flag fell");

   property p_summary;
      @(posedge clock) disable iff (rst) stat_view[7] == (second_status != 8'h00);
   endproperty
   a_summary: assert property (p_summary) else $error("summary bit wrong");

   // write steps: an open write takes every writable bit, a locked one only full speed
   sequence s_open_write;
      wr_cfg && !cfg_r[mcsr_pkg::MCSR_B_LOCK];
   endsequence

   sequence s_locked_write;
      wr_cfg && cfg_r[mcsr_pkg::MCSR_B_LOCK];
   endsequence

   // flags are only set at a monitoring cycle end while running
   sequence s_cycle_end;
      cfg_r[mcsr_pkg::MCSR_B_RUN] && cycle_done;
   endsequence

   property p_run_write;
      @(posedge clock) disable iff (rst) s_open_write |=> cfg_r[mcsr_pkg::MCSR_B_RUN] == $past(pwdata[mcsr_pkg::MCSR_B_RUN]);
   endproperty
   a_run_write: assert property (p_run_write) else $error("run bit write lost");

   property p_lock_write;
      @(posedge clock) disable iff (rst) s_open_write |=> cfg_r[mcsr_pkg::MCSR_B_LOCK] == $past(pwdata[mcsr_pkg::MCSR_B_LOCK]);
   endproperty
   a_lock_write: assert property (p_lock_write) else $error("lock bit write lost");

   property p_skip_write;
      @(posedge clock) disable iff (rst) s_open_write |=> cfg_r[mcsr_pkg::MCSR_B_SKIP] == $past(pwdata[mcsr_pkg::MCSR_B_SKIP]);
   endproperty
   a_skip_write: assert property (p_skip_write) else $error("spin-up skip write lost");

   property p_tooff_write;
      @(posedge clock) disable iff (rst) s_open_write |=> cfg_r[mcsr_pkg::MCSR_B_TOOFF] == $past(pwdata[mcsr_pkg::MCSR_B_TOOFF]);
   endproperty
   a_tooff_write: assert property (p_tooff_write) else $error("timeout disable write lost");

   property p_scale_write;
      @(posedge clock) disable iff (rst) s_open_write |=> cfg_r[mcsr_pkg::MCSR_B_SCALE] == $past(pwdata[mcsr_pkg::MCSR_B_SCALE]);
   endproperty
   a_scale_write: assert property (p_scale_write) else $error("supply scale write lost");

   property p_locked_only_max;
      @(posedge clock) disable iff (rst) s_locked_write |=> $stable(cfg_r[7:4]) && $stable(cfg_r[2:0]);
   endproperty
   a_locked_only_max: assert property (p_locked_only_max) else $error("locked write changed a frozen bit");

   property p_no_write_hold;
      @(posedge clock) disable iff (rst) !wr_cfg |=> $stable(cfg_r);
   endproperty
   a_no_write_hold: assert property (p_no_write_hold) else $error("config changed without a write");

   property p_ready_wait;
      @(posedge clock) disable iff (rst) !rdy_r |-> rcnt_r < 32'(READY_CYC);
   endproperty
   a_ready_wait: assert property (p_ready_wait) else $error("ready counter overran");

   property p_low_rail_set;
      @(posedge clock) disable iff (rst) s_cycle_end ##0 viol[0] |=> stat_r[mcsr_pkg::MCSR_S_LOW_RAIL];
   endproperty
   a_low_rail_set: assert property (p_low_rail_set) else $error("low rail flag not set");

   property p_local_set;
      @(posedge clock) disable iff (rst) s_cycle_end ##0 viol[3] |=> stat_r[mcsr_pkg::MCSR_S_LOCAL];
   endproperty
   a_local_set: assert property (p_local_set) else $error("local flag not set");

   property p_rem2_set;
      @(posedge clock) disable iff (rst) s_cycle_end ##0 viol[4] |=> stat_r[mcsr_pkg::MCSR_S_REM2];
   endproperty
   a_rem2_set: assert property (p_rem2_set) else $error("remote two flag not set");

   property p_read_clears;
      @(posedge clock) disable iff (rst) cfg_r[mcsr_pkg::MCSR_B_RUN] && rd_stat && !cycle_done && !viol[0] |=> !stat_r[0];
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("flag kept after condition went");

   property p_read_set_wins;
      @(posedge clock) disable iff (rst) s_cycle_end ##0 (rd_stat && viol[2]) |=> stat_r[mcsr_pkg::MCSR_S_REM1];
   endproperty
   a_read_set_wins: assert property (p_read_set_wins) else $error("flag lost under a read");

   property p_idle_no_set;
      @(posedge clock) disable iff (rst) !cfg_r[mcsr_pkg::MCSR_B_RUN] |=> (stat_r & ~$past(stat_r)) == 8'h00;
   endproperty
   a_idle_no_set: assert property (p_idle_no_set) else $error("flag set while stopped");

   property p_idle_read_clears;
      @(posedge clock) disable iff (rst) !cfg_r[mcsr_pkg::MCSR_B_RUN] && rd_stat |=> stat_r == 8'h00;
   endproperty
   a_idle_read_clears: assert property (p_idle_read_clears) else $error("stopped read left a flag");

   property p_no_spurious;
      @(posedge clock) disable iff (rst) cfg_r[mcsr_pkg::MCSR_B_RUN] && !cycle_done && !rd_stat |=> $stable(stat_r);
   endproperty
   a_no_spurious: assert property (p_no_spurious) else $error("flags moved between cycle ends");

   property p_summary_live;
      @(posedge clock) disable iff (rst) !stat_r[mcsr_pkg::MCSR_S_SUMMARY];
   endproperty
   a_summary_live: assert property (p_summary_live) else $error("summary bit latched");

   // compare edges: strictly above high, at or below low
   property p_high_cmp;
      @(posedge clock) disable iff (rst) chan[0].value > chan[0].high_lim |-> viol[0];
   endproperty
   a_high_cmp: assert property (p_high_cmp) else $error("high violation missed");

   property p_low_cmp;
      @(posedge clock) disable iff (rst) chan[1].value <= chan[1].low_lim |-> viol[1];
   endproperty
   a_low_cmp: assert property (p_low_cmp) else $error("low violation missed");

   property p_in_range;
      @(posedge clock) disable iff (rst) chan[2].value > chan[2].low_lim && chan[2].value <= chan[2].high_lim |-> !viol[2];
   endproperty
   a_in_range: assert property (p_in_range) else $error("in-range value flagged");
endmodule : mcsr_regs

// ===== mcsr_front.sv
// stand-in for the measurement front end: readings against fixed limits
// assumes the bench picks which channels are out of range
`timescale 1ns/1ps
module mcsr_front (
   input  wire logic                                        clock,
   input  wire logic                                        rst,
   input  wire logic [4:0]                                  want,
   output logic                                             cycle_done,
   output mcsr_pkg::mcsr_chan_t [mcsr_pkg::MCSR_NCH-1:0]    chan
);
   logic [3:0] cnt_r;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) cnt_r <= 4'h0;
      else cnt_r <= cnt_r + 4'h1;
   end
   assign cycle_done = (cnt_r[2:0] == 3'h7);
   // readings sit right on the compare edges, high side and low side in turn
   always_comb begin
      for (int i = 0; i < mcsr_pkg::MCSR_NCH; i++) begin
         chan[i].low_lim = 8'h10;
         chan[i].high_lim = 8'h80;
         if (cnt_r[3]) chan[i].value = want[i] ? 8'h81 : 8'h80;
         else chan[i].value = want[i] ? 8'h10 : 8'h11;
      end
   end
endmodule : mcsr_front

// ===== mcsr_regs_bench.sv
// self-checking bench for the config and first status registers
// assumes mcsr_front supplies readings; ready delay cut to 4 cycles
`timescale 1ns/1ps
module mcsr_regs_bench;
   localparam int RDY = 4;
   logic clock, rst, psel, penable, pwrite, pready, pslverr, cycle_done, device_ready, serr;
   logic [9:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   logic [3:0]  pstrb;
   logic [4:0]  want;
   logic [7:0]  second_status, d, e, cfg, left;
   mcsr_pkg::mcsr_chan_t [mcsr_pkg::MCSR_NCH-1:0] chan;
   mcsr_pkg::mcsr_ctrl_t ctrl;
   int err_count = 0;
   int num_checks = 0;
   mcsr_regs #(.READY_CYC(RDY)) mcsr_regs_i (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cycle_done(cycle_done), .chan(chan), .second_status(second_status),
      .ctrl(ctrl), .device_ready(device_ready));
   mcsr_front mcsr_front_i (.clock(clock), .rst(rst), .want(want), .cycle_done(cycle_done), .chan(chan));
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task apb(input logic w, input logic [9:0] a, input logic [7:0] wd);
      int n;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, wd};
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) err_count++;
      q = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   function automatic logic [7:0] exp_stat(input logic [4:0] w, input logic [7:0] ss);
      return {|ss, w[4:2], 1'b0, w[1], 1'b0, w[0]};
   endfunction : exp_stat
   task summarize();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : summarize
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   initial begin
      #(50 * 3000);
      err_count++;
      summarize();
   end
   initial begin
      {rst, pstrb} = 5'h1f;
      {psel, penable, pwrite, paddr, pwdata, want, second_status} = '0;
      void'($urandom(32'hff407ed0));
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      #1 chk("ready_early", 32'h0, 32'(device_ready));
      repeat (RDY + 1) @(posedge clock);
      chk("ready", 32'h1, 32'(device_ready));
      apb(1'b0, mcsr_pkg::MCSR_ADDR_CFG, 8'h00);
      chk("cfg_reset", 32'h04, q);
      cfg = 8'h04;
      for (int i = 0; i < 6; i++) begin
         d = 8'($urandom()) & 8'hfd;
         apb(1'b1, mcsr_pkg::MCSR_ADDR_CFG, d);
         cfg = (d & mcsr_pkg::MCSR_CFG_WMASK) | 8'h04;
         apb(1'b0, mcsr_pkg::MCSR_ADDR_CFG, 8'h00);
         chk("cfg", 32'(cfg), q);
         chk("ctrl", 32'({cfg[0], cfg[3], cfg[5], cfg[6], cfg[7], cfg[1]}), 32'(ctrl));
      end
      $display("test config done");
      // limits come from the front end and are fixed before the run bit goes up
      apb(1'b1, mcsr_pkg::MCSR_ADDR_CFG, 8'h01);
      // flags kept by a read whose condition stayed carry into the next round
      left = 8'h00;
      for (int i = 0; i < 6; i++) begin
         want <= 5'($urandom());
         second_status <= 8'($urandom()) & {8{i[1]}};
         repeat (20) @(posedge clock);
         e = exp_stat(want, second_status) | left;
         if (!i[0]) want <= 5'h0;
         apb(1'b0, mcsr_pkg::MCSR_ADDR_STAT, 8'h00);
         chk("stat", 32'(e), q);
         apb(1'b0, mcsr_pkg::MCSR_ADDR_STAT, 8'h00);
         chk("stat_again", 32'(i[0] ? e : e & 8'h80), q);
         left = i[0] ? (e & 8'h7f) : 8'h00;
      end
      apb(1'b1, mcsr_pkg::MCSR_ADDR_CFG, 8'h00);
      want <= 5'h1f;
      repeat (20) @(posedge clock);
      apb(1'b0, mcsr_pkg::MCSR_ADDR_STAT, 8'h00);
      chk("stat_idle", 32'({|second_status, 7'h0} | left), q);
      apb(1'b0, mcsr_pkg::MCSR_ADDR_STAT, 8'h00);
      chk("stat_idle_clear", 32'({|second_status, 7'h0}), q);
      $display("test status done");
      apb(1'b1, mcsr_pkg::MCSR_ADDR_CFG, 8'h43);
      cfg = 8'h47;
      for (int i = 0; i < 4; i++) begin
         d = 8'($urandom());
         apb(1'b1, mcsr_pkg::MCSR_ADDR_CFG, d);
         cfg = {cfg[7:4], d[3], cfg[2:0]};
         apb(1'b0, mcsr_pkg::MCSR_ADDR_CFG, 8'h00);
         chk("cfg_locked", 32'(cfg), q);
      end
      $display("test lock done");
      apb(1'b1, 10'h3fc, 8'hff);
      apb(1'b0, 10'h3fc, 8'h00);
      chk("unmapped", 32'h0, q);
      chk("slverr", 32'h1, 32'(serr));
      chk("pready", 32'h1, 32'(pready));
      $display("test unmapped done");
      summarize();
   end
endmodule : mcsr_regs_bench
